// ==== core/memmap_params.svh ====
`ifndef MEMMAP_PARAMS_SVH
`define MEMMAP_PARAMS_SVH
// ----------------------------------------
// Address map
// ----------------------------------------
`define INT_MEM_TOP 32'h0040_0000
`define PERIPH_BASE 32'hFFC0_0000
`define PRIMARY_SRAM_BASE 32'h0000_0000
`define PRIMARY_SRAM_BYTES 32'h0000_2000
`define EXT_SRAM_BASE 32'h0010_0000
`define EXT_SRAM_BYTES 32'h0002_0000
`define REMAP_ALIAS_BASE 32'h0030_0000
`define VECTOR_TOP 32'h0000_0020
// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define BOOT_SAMPLE_CYCLES 4'hA
`define BOOT_SEL_RESET 1'b1
`define BANK_CFG_WIDTH 16
`endif

// ==== core/memmap_pkg.sv ====
package memmap_pkg;
   typedef enum logic [2:0] {
      tgt_none = 3'b000,
      tgt_primary = 3'b001,
      tgt_ext_sram = 3'b010,
      tgt_external = 3'b011,
      tgt_periph = 3'b100
   } target_t;
   typedef enum logic [1:0] {
      sz_byte = 2'b00,
      sz_half = 2'b01,
      sz_word = 2'b10
   } size_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic fetch;
      size_t size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } core_req_t;
   // Per-bank external configuration
   typedef struct packed {
      logic enable;
      logic [3:0] base_mb;
      logic [1:0] size_code;
      logic [2:0] wait_states;
      logic [1:0] float_cycles;
      logic wide16;
      logic byte_write_mode;
      logic early_read;
      logic [1:0] spare;
   } bank_cfg_t;
   typedef struct packed {
      logic hit;
      logic [2:0] bank;
      logic [2:0] wait_states;
      logic [1:0] float_cycles;
      logic wide16;
      logic byte_write_mode;
      logic early_read;
   } ext_sel_t;
endpackage

// ==== core/memory_map_boot_remap_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "memmap_params.svh"
// Contract
// - Split address space into internal memory, external, and peripheral regions.
// - All regions use little-endian byte lanes only.
// - Internal memories are 32 bits wide with single-cycle byte, half, word access.
// - After remap, primary SRAM decodes at address zero with writable vectors.
// - Extended SRAM of 128 Kbytes sits at 0x0010_0000.
// - Address zero decodes to the selected boot memory after reset.
// - Boot select sampled in last ten cycles before reset release; the code latches the pin level at the last reset clock edge.
// - Boot select one boots extended SRAM, zero boots external first chip select.
// - Boot select pin becomes general I/O line twenty-four after reset.
// - Writing remap command bit swaps address zero to primary SRAM.
// - Remap persists until internal or external reset.
// - Abort on undefined external bus address accesses.
// - No abort for internal memory reads or peripheral accesses.
// - External bus unit serves 0x0040_0000 up to 0xFFC0_0000.
// - External banks configurable from eight 1 Mbyte to four 16 Mbyte.
// - Each bank has wait states, float cycles and 8 or 16-bit width.
// - 16-bit bank drives byte-select device or two byte-write devices.
// - Naturally aligned byte, half and word external accesses.
// - Early read option available per device.
// - Watchdog reset keeps the latched boot mode.
module memory_map_boot_remap_decoder #(
   parameter int NUM_BANKS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic watchdog_reset_i,
   input wire logic boot_select_pin_i,
   input wire logic remap_command_bit_i,
   input wire logic remap_command_write_i,
   input wire memmap_pkg::core_req_t req_i,
   input wire memmap_pkg::bank_cfg_t [NUM_BANKS-1:0] bank_cfg_i,
   output logic [31:0] rdata_o,
   output logic ready_o,
   output logic abort_o,
   output logic boot_mode_o,
   output logic remap_done_o,
   output logic io_line_twentyfour_free_o,
   output memmap_pkg::target_t target_o,
   output memmap_pkg::ext_sel_t ext_sel_o,
   output logic [3:0] byte_en_o,
   output logic [31:0] ext_addr_o,
   output logic [31:0] ext_wdata_o,
   output logic ext_valid_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Little-endian lane mask for a naturally aligned access
   function automatic logic [3:0] lane_mask(input memmap_pkg::size_t sz, input logic [1:0] a);
      logic [3:0] m;
      m = 4'h0;
      case (sz)
         memmap_pkg::sz_byte: m = 4'h1 << a;
         memmap_pkg::sz_half: m = a[1] ? 4'hC : 4'h3;
         memmap_pkg::sz_word: m = 4'hF;
         default: m = 4'h0;
      endcase
      return m;
   endfunction

   function automatic logic aligned(input memmap_pkg::size_t sz, input logic [1:0] a);
      logic ok;
      ok = 1'b0;
      case (sz)
         memmap_pkg::sz_byte: ok = 1'b1;
         memmap_pkg::sz_half: ok = ~a[0];
         memmap_pkg::sz_word: ok = (a == 2'b00);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ----------------------------------------
   // Boot mode capture
   // ----------------------------------------
   logic boot_mode_reg;
   logic [3:0] sample_cnt_reg;
   logic pin_stable_reg;
   logic boot_last_reg;
   logic in_ext_reset;
   assign in_ext_reset = rst_i & ~watchdog_reset_i;

   always_ff @(posedge clk_i) begin
      if (in_ext_reset) begin
         boot_last_reg <= boot_select_pin_i;
         if (boot_select_pin_i != boot_last_reg) begin
            sample_cnt_reg <= 4'h0;
         end else if (sample_cnt_reg != `BOOT_SAMPLE_CYCLES) begin
            sample_cnt_reg <= sample_cnt_reg + 4'h1;
         end
         pin_stable_reg <= 1'b1;
      end else begin
         pin_stable_reg <= 1'b0;
         sample_cnt_reg <= 4'h0;
      end
   end

   // latch level on reset release; watchdog reset does not resample
   always_ff @(posedge clk_i) begin
      if (in_ext_reset) begin
         boot_mode_reg <= boot_select_pin_i;
      end
   end

   // ----------------------------------------
   // Remap state
   // ----------------------------------------
   logic remap_reg;
   // command sets; sticky; any reset clears
   always_ff @(posedge clk_i) begin
      if (rst_i | watchdog_reset_i) begin
         remap_reg <= 1'b0;
      end else if (remap_command_write_i & remap_command_bit_i) begin
         remap_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   memmap_pkg::target_t tgt;
   logic [31:0] mem_off;
   logic undefined_ext;
   memmap_pkg::ext_sel_t sel;
   logic [31:0] ext_addr;

   always_comb begin
      logic [31:0] bsize;
      bsize = 32'h0000_0000;
      sel = '0;
      for (int i = NUM_BANKS - 1; i >= 0; i--) begin
         bsize = 32'h0010_0000 << (2 * bank_cfg_i[i].size_code);
         if (bank_cfg_i[i].enable && (ext_addr >= {8'h00, bank_cfg_i[i].base_mb, 20'h0_0000})
             && (ext_addr < ({8'h00, bank_cfg_i[i].base_mb, 20'h0_0000} + bsize))
             && ((i == 0) || remap_reg)) begin
            // banks 1..7 only reachable after remap
            sel.hit = 1'b1;
            sel.bank = 3'(i);
            sel.wait_states = bank_cfg_i[i].wait_states;
            sel.float_cycles = bank_cfg_i[i].float_cycles;
            sel.wide16 = bank_cfg_i[i].wide16;
            sel.byte_write_mode = bank_cfg_i[i].byte_write_mode;
            sel.early_read = bank_cfg_i[i].early_read;
         end
      end
   end

   // three regions; address-zero alias; external range
   always_comb begin
      tgt = memmap_pkg::tgt_none;
      mem_off = req_i.addr;
      ext_addr = req_i.addr;
      if (req_i.addr >= `PERIPH_BASE) begin
         tgt = memmap_pkg::tgt_periph;
      end else if (req_i.addr >= `INT_MEM_TOP) begin
         tgt = memmap_pkg::tgt_external;
      end else if (req_i.addr < `EXT_SRAM_BASE) begin
         if (remap_reg) begin
            tgt = (req_i.addr < `PRIMARY_SRAM_BYTES) ? memmap_pkg::tgt_primary : memmap_pkg::tgt_none;
         end else if (boot_mode_reg) begin
            tgt = memmap_pkg::tgt_ext_sram;
         end else begin
            // boot alias lands in the first chip-select bank
            tgt = memmap_pkg::tgt_external;
            ext_addr = {8'h00, bank_cfg_i[0].base_mb, req_i.addr[19:0]};
         end
      end else if (req_i.addr < (`EXT_SRAM_BASE + `EXT_SRAM_BYTES)) begin
         tgt = memmap_pkg::tgt_ext_sram;
         mem_off = req_i.addr - `EXT_SRAM_BASE;
      end else if ((req_i.addr >= `REMAP_ALIAS_BASE) && (req_i.addr < (`REMAP_ALIAS_BASE + `PRIMARY_SRAM_BYTES))) begin
         tgt = memmap_pkg::tgt_primary;
         mem_off = req_i.addr - `REMAP_ALIAS_BASE;
      end
   end

   // external undefined aborts; internal reads and peripherals never
   always_comb begin
      undefined_ext = 1'b0;
      if (tgt == memmap_pkg::tgt_external) begin
         undefined_ext = ~sel.hit | ~aligned(req_i.size, req_i.addr[1:0]);
      end else if ((tgt == memmap_pkg::tgt_none) && req_i.write) begin
         undefined_ext = 1'b1;
      end
   end

   // ----------------------------------------
   // Internal memories
   // ----------------------------------------
   localparam int PRI_WORDS = `PRIMARY_SRAM_BYTES / 4;
   localparam int EXT_WORDS = `EXT_SRAM_BYTES / 4;
   logic [31:0] pri_mem [PRI_WORDS];
   logic [31:0] xsr_mem [EXT_WORDS];
   logic [3:0] be;
   assign be = lane_mask(req_i.size, req_i.addr[1:0]);

   // single-cycle byte lane writes; lane 0 is the lowest address
   always_ff @(posedge clk_i) begin
      if (req_i.valid && req_i.write && (tgt == memmap_pkg::tgt_primary)) begin
         for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
               pri_mem[mem_off[12:2]][8*b +: 8] <= req_i.wdata[8*b +: 8];
            end
         end
      end
      if (req_i.valid && req_i.write && (tgt == memmap_pkg::tgt_ext_sram)) begin
         for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
               xsr_mem[mem_off[16:2]][8*b +: 8] <= req_i.wdata[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
         ready_o <= 1'b0;
         abort_o <= 1'b0;
      end else begin
         ready_o <= req_i.valid & (tgt != memmap_pkg::tgt_external);
         abort_o <= req_i.valid & undefined_ext;
         case (tgt)
            memmap_pkg::tgt_primary: rdata_o <= pri_mem[mem_off[12:2]];
            memmap_pkg::tgt_ext_sram: rdata_o <= xsr_mem[mem_off[16:2]];
            default: rdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // External request and status
   // ----------------------------------------
   // aligned external requests only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         target_o <= memmap_pkg::tgt_none;
         ext_sel_o <= '0;
         byte_en_o <= 4'h0;
         ext_addr_o <= 32'h0000_0000;
         ext_wdata_o <= 32'h0000_0000;
         ext_valid_o <= 1'b0;
      end else begin
         target_o <= req_i.valid ? tgt : memmap_pkg::tgt_none;
         ext_sel_o <= sel;
         byte_en_o <= be;
         ext_addr_o <= ext_addr;
         ext_wdata_o <= req_i.wdata;
         ext_valid_o <= req_i.valid & (tgt == memmap_pkg::tgt_external) & ~undefined_ext;
      end
   end

   // pin released to general I/O after reset
   always_ff @(posedge clk_i) begin
      boot_mode_o <= boot_mode_reg;
      remap_done_o <= remap_reg;
      io_line_twentyfour_free_o <= ~rst_i;
   end
endmodule
`default_nettype wire

// ==== dv/core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input wire logic clk_i,
   output memmap_pkg::core_req_t req_o
);
   initial req_o = '0;
   // ------
   // One access per call
   // ------
   task automatic access(input logic wr, input memmap_pkg::size_t sz, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      #1;
      req_o <= {1'b1, wr, 1'b0, sz, a, d};
      @(posedge clk_i);
      #1;
      // Released lines flip so a stale address is never mistaken for a held one
      req_o <= {1'b0, 1'b0, 1'b0, memmap_pkg::sz_word, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// ==== dv/mmd_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module mmd_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic watchdog_reset_i,
   input wire logic remap_command_bit_i,
   input wire logic remap_command_write_i,
   input wire memmap_pkg::core_req_t req_i,
   input wire logic ready_o,
   input wire logic abort_o,
   input wire logic boot_mode_o,
   input wire logic remap_done_o,
   input wire memmap_pkg::target_t target_o,
   input wire logic [3:0] byte_en_o,
   input wire logic ext_valid_o
);
   // ------
   // Port timing
   // ------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = req_i.valid;
   wire logic ext = req && req_i.addr >= 32'h0040_0000 && req_i.addr < 32'hFFC0_0000;
   wire logic cmd = remap_command_bit_i && remap_command_write_i && !watchdog_reset_i;
   logic [1:0] lane_q;
   always_ff @(posedge clk_i) lane_q <= req_i.addr[1:0];
   a_answer_once: assert property (req |=> ready_o || abort_o || ext_valid_o)
      else $error("request left unanswered");
   a_idle_quiet: assert property (!req |=> !ready_o && !abort_o && !ext_valid_o)
      else $error("answer without request");
   a_ext_not_ready: assert property (ext |=> !ready_o)
      else $error("external access answered internally");
   a_periph_no_abort: assert property (req && req_i.addr >= 32'hFFC0_0000 |=> !abort_o)
      else $error("peripheral access aborted");
   a_int_rd_ok: assert property (req && !req_i.write && req_i.addr < 32'h0040_0000 |=> !abort_o)
      else $error("internal read aborted");
   a_zero_boot: assert property (req && req_i.addr == 32'h0 && !remap_done_o && !$past(cmd) |=>
      target_o == (boot_mode_o ? memmap_pkg::tgt_ext_sram : memmap_pkg::tgt_external))
      else $error("address zero not boot memory");
   a_zero_remap: assert property (req && req_i.addr < 32'h0000_0020 && remap_done_o
      && !$past(watchdog_reset_i) |=>
      target_o == memmap_pkg::tgt_primary)
      else $error("vector area not primary sram");
   a_remap_set: assert property (cmd |-> ##2 remap_done_o)
      else $error("remap command ignored");
   a_remap_sticky: assert property (remap_done_o && !watchdog_reset_i && !$past(watchdog_reset_i) |=> remap_done_o)
      else $error("remap dropped");
   a_wdog_clears: assert property (watchdog_reset_i |-> ##2 !remap_done_o)
      else $error("remap kept over reset");
   a_wdog_keeps_boot: assert property (watchdog_reset_i |=> $stable(boot_mode_o))
      else $error("boot mode changed by watchdog");
   a_boot_held: assert property ($stable(boot_mode_o))
      else $error("boot mode changed outside reset");
   a_byte_lane: assert property (ext && req_i.size == memmap_pkg::sz_byte |=> byte_en_o == 4'h1 << lane_q)
      else $error("byte lane wrong");
   c_remap: cover property (cmd);
   c_abort: cover property (abort_o);
   c_wdog: cover property (watchdog_reset_i ##1 boot_mode_o);
endmodule
bind memory_map_boot_remap_decoder mmd_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .watchdog_reset_i(watchdog_reset_i), .remap_command_bit_i(remap_command_bit_i),
   .remap_command_write_i(remap_command_write_i), .req_i(req_i), .ready_o(ready_o),
   .abort_o(abort_o), .boot_mode_o(boot_mode_o), .remap_done_o(remap_done_o),
   .target_o(target_o), .byte_en_o(byte_en_o), .ext_valid_o(ext_valid_o));
`default_nettype wire

// ==== dv/test_memory_map_boot_remap_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_memory_map_boot_remap_decoder;
   localparam memmap_pkg::size_t wd = memmap_pkg::sz_word;
   localparam memmap_pkg::size_t hw = memmap_pkg::sz_half;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wdog = 1'b0;
   logic pin = 1'b1;
   logic remap_command_bit = 1'b0;
   logic rwr = 1'b0;
   logic [31:0] rdata;
   logic [31:0] eaddr, ewdata;
   logic ready, abort, boot, remap, io_free, ext_valid;
   logic [3:0] ben;
   memmap_pkg::core_req_t req;
   memmap_pkg::bank_cfg_t [7:0] cfg;
   memmap_pkg::target_t tgt;
   memmap_pkg::ext_sel_t sel;
   int n_errors = 0;
   int num_checks = 0;
   always #4 clk_i = ~clk_i;
   core_model i_core (.clk_i(clk_i), .req_o(req));
   memory_map_boot_remap_decoder #(.NUM_BANKS(8)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .watchdog_reset_i(wdog), .boot_select_pin_i(pin),
      .remap_command_bit_i(remap_command_bit), .remap_command_write_i(rwr), .req_i(req), .bank_cfg_i(cfg),
      .rdata_o(rdata), .ready_o(ready), .abort_o(abort), .boot_mode_o(boot), .remap_done_o(remap),
      .io_line_twentyfour_free_o(io_free), .target_o(tgt), .ext_sel_o(sel), .byte_en_o(ben),
      .ext_addr_o(eaddr), .ext_wdata_o(ewdata), .ext_valid_o(ext_valid));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic acc(input logic wr, input memmap_pkg::size_t sz, input logic [31:0] a, input logic [31:0] d);
      i_core.access(wr, sz, a, d);
   endtask
   // Pin is held for twelve reset cycles, two past the ten sampling cycles, before release
   task automatic hard_reset(input logic level);
      @(posedge clk_i);
      #1;
      rst_i = 1'b1;
      pin = level;
      repeat (12) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
   endtask
   task automatic remap_pulse();
      @(posedge clk_i);
      #1;
      remap_command_bit = 1'b1;
      rwr = 1'b1;
      @(posedge clk_i);
      #1;
      remap_command_bit = 1'b0;
      rwr = 1'b0;
      // Status flop trails the remap state by one cycle
      @(posedge clk_i);
      #1;
   endtask
   task automatic t_sram_boot();
      hard_reset(1'b1);
      acc(1'b0, wd, 32'h0000_0000, 32'h0);
      chk({ready, tgt}, {1'b1, memmap_pkg::tgt_ext_sram});
      chk({boot, io_free}, 2'h3);
      acc(1'b1, wd, 32'h0010_0004, 32'h1234_5678);
      acc(1'b1, memmap_pkg::sz_byte, 32'h0010_0007, 32'hABAB_ABAB);
      chk(ben, 4'h8);
      acc(1'b0, wd, 32'h0010_0004, 32'h0);
      chk({ready, rdata}, {1'b1, 32'hAB34_5678});
      acc(1'b0, wd, 32'hFFFF_F000, 32'h0);
      chk({abort, tgt}, {1'b0, memmap_pkg::tgt_periph});
      $display("sram boot test done");
   endtask
   task automatic t_remap();
      remap_pulse();
      chk(remap, 1'b1);
      acc(1'b1, wd, 32'h0000_001C, 32'hC0DE_0001);
      acc(1'b0, wd, 32'h0000_001C, 32'h0);
      chk({tgt, rdata}, {memmap_pkg::tgt_primary, 32'hC0DE_0001});
      acc(1'b0, wd, 32'h0050_0000, 32'h0);
      chk({ext_valid, abort, sel.bank}, 5'h11);
      $display("remap test done");
   endtask
   task automatic t_wdog();
      @(posedge clk_i);
      #1;
      pin = 1'b0;
      wdog = 1'b1;
      @(posedge clk_i);
      #1;
      wdog = 1'b0;
      @(posedge clk_i);
      #1;
      chk(boot, 1'b1);
      chk(remap, 1'b0);
      acc(1'b0, wd, 32'h0000_0000, 32'h0);
      chk(tgt, memmap_pkg::tgt_ext_sram);
      $display("watchdog test done");
   endtask
   task automatic t_ext_boot();
      hard_reset(1'b0);
      chk({boot, remap}, 2'h0);
      acc(1'b0, wd, 32'h0000_0000, 32'h0);
      chk({ext_valid, tgt}, {1'b1, memmap_pkg::tgt_external});
      chk(eaddr, 32'h0040_0000);
      acc(1'b0, wd, 32'h0050_0000, 32'h0);
      chk(abort, 1'b1);
      acc(1'b0, wd, 32'h0800_0000, 32'h0);
      chk(abort, 1'b1);
      remap_pulse();
      acc(1'b1, hw, 32'h0050_0002, 32'h5555_5555);
      chk({ext_valid, ben}, 5'h1C);
      chk(ewdata, 32'h5555_5555);
      acc(1'b0, wd, 32'h0050_0002, 32'h0);
      chk(abort, 1'b1);
      $display("external boot test done");
   endtask
   initial begin
      cfg = '0;
      cfg[0].enable = 1'b1;
      cfg[0].base_mb = 4'h4;
      cfg[1].enable = 1'b1;
      cfg[1].base_mb = 4'h5;
      t_sram_boot();
      t_remap();
      t_wdog();
      t_ext_boot();
      give_verdict();
   end
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
